// [src/tof_pkg.sv]
// shared constants, types and register map of the time-of-flight counter block
package tof_pkg;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          CNT_W           = 16;
    localparam int          FINE_W          = 24;
    localparam int          IDX_W           = 3;
    localparam int          FINE_SLOTS      = 6;
    localparam int          CLK_SLOTS       = 5;

    // register byte addresses
    localparam logic [7:0]  CONTROL_ADDR      = 8'h00;
    localparam logic [7:0]  STATUS_ADDR       = 8'h04;
    localparam logic [7:0]  COARSE_HIGH_ADDR  = 8'h08;
    localparam logic [7:0]  COARSE_LOW_ADDR   = 8'h0C;
    localparam logic [7:0]  REFCLK_HIGH_ADDR  = 8'h10;
    localparam logic [7:0]  REFCLK_LOW_ADDR   = 8'h14;
    localparam logic [7:0]  CAL_RESULT_ADDR   = 8'h18;
    localparam logic [7:0]  FINE_BASE_ADDR    = 8'h20;
    localparam logic [7:0]  CLK_BASE_ADDR     = 8'h40;
    localparam logic [7:0]  SLOT_STRIDE       = 8'h04;

    // control register fields
    localparam int          CTRL_START_BIT  = 0;
    localparam int          CTRL_MODE2_BIT  = 1;
    localparam int          CTRL_CAL_BIT    = 2;
    localparam int          CTRL_NSTOP_LSB  = 3;
    // status register fields
    localparam int          STAT_COARSE_BIT = 0;
    localparam int          STAT_REFCLK_BIT = 1;
    localparam int          STAT_BUSY_BIT   = 2;
    localparam int          STAT_DONE_BIT   = 3;
    localparam int          STAT_NREC_LSB   = 4;

    localparam logic [2:0]  NSTOP_RESET     = 3'h1;
    localparam logic [2:0]  NSTOP_MAX       = 3'h5;
    localparam logic [7:0]  LIMIT_RESET     = 8'hFF;
    localparam logic [23:0] WRAP_STEPS      = 24'h00003F;
    localparam logic [15:0] CAL_PERIODS     = 16'h000A;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_START,
        ST_RUN,
        ST_CAL,
        ST_DONE
    } meas_state_type;

    typedef struct packed {
        logic        mode2;
        logic        cal;
        logic [2:0]  num_stops;
        logic [15:0] coarse_limit;
        logic [15:0] refclk_limit;
    } meas_cfg_type;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } avalon_req_type;

endpackage : tof_pkg

// [src/serial_status_port.sv]
// serial status shifter: presents one status byte on the serial output pin
module serial_status_port (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       sclk_pin,
    input  wire logic       chip_select_n_pin,
    input  wire logic [7:0] status_byte,
    output logic            serial_out
);

    logic [1:0] sclk_sync_reg;
    logic [1:0] cs_sync_reg;
    logic       sclk_last_reg;
    logic       cs_last_reg;
    logic [7:0] shift_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_sync_reg <= 2'h0;
            cs_sync_reg   <= 2'h3;
            sclk_last_reg <= 1'b0;
            cs_last_reg   <= 1'b1;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[0], sclk_pin};
            cs_sync_reg   <= {cs_sync_reg[0], chip_select_n_pin};
            sclk_last_reg <= sclk_sync_reg[1];
            cs_last_reg   <= cs_sync_reg[1];
        end
    end

    // host frames the access with select low around every rising edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            shift_reg  <= 8'h00;
            serial_out <= 1'b0;
        end else if (cs_last_reg && !cs_sync_reg[1]) begin
            shift_reg  <= {status_byte[6:0], 1'b0};
            serial_out <= status_byte[7];
        end else if (!cs_sync_reg[1] && sclk_last_reg && !sclk_sync_reg[1]) begin
            // output moves only after a falling serial clock edge
            serial_out <= shift_reg[7];
            shift_reg  <= {shift_reg[6:0], 1'b0};
        end
    end

endmodule : serial_status_port

// [src/tof_counter_overflow.sv]
// coarse and reference-clock counters with overflow detection and register slave
// Functional notes
// - time is measured from one start edge to several later stop edges.
// - coarse counter counts ring oscillator wraps; it forms every fine result.
// - mode 2 only: count whole reference cycles per stop, up to five results.
// - coarse flag sets when fine result over 63 reaches the 16-bit coarse limit.
// - reference flag sets when a clock count exceeds the 16-bit clock limit.
// - any overflow ends the measurement at once; no more stops recorded.
// - the reference clock is the yardstick for calibrating the time base.
// - serial output changes after falling serial clock edges.
// - enable acts as reset for all digital logic.
// - clock counting starts at first reference edge after start.
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
module tof_counter_overflow (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        refclk,
    input  wire logic        enable_pin,
    input  wire logic        start_pin,
    input  wire logic        stop_pin,
    input  wire logic        ring_wrap_pin,
    input  wire logic        sclk_pin,
    input  wire logic        chip_select_n,
    output logic             serial_out,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);

    ////////////////////////////////////////////////////////////////////////////
    // system clock side: enable as reset, bus slave, configuration

    tof_pkg::avalon_req_type req;
    tof_pkg::meas_cfg_type   cfg_reg;
    logic [1:0]              en_sync_reg;
    logic                    soft_rst_reg;
    logic                    mrst;
    logic                    arm_tog_reg;
    logic                    clr_tog_reg;
    logic [7:0]              coarse_limit_high_reg;
    logic [7:0]              coarse_limit_low_reg;
    logic [7:0]              refclk_limit_high_reg;
    logic [7:0]              refclk_limit_low_reg;
    logic                    mode2_reg;
    logic [2:0]              num_stops_reg;
    logic [3:0]              stat_sync1_reg;
    logic [3:0]              stat_sync2_reg;
    logic                    accept;
    logic [31:0]             read_next;
    logic [7:0]              status_byte;
    logic [2:0]              nstop_wr;
    logic [2:0]              nstop_next;

    assign req  = '{read: avs_read, write: avs_write, address: avs_address,
                    writedata: avs_writedata};
    assign mrst = rst | soft_rst_reg;
    assign nstop_wr   = req.writedata[tof_pkg::CTRL_NSTOP_LSB +: 3];
    assign nstop_next = (nstop_wr != 3'h0 && nstop_wr <= tof_pkg::NSTOP_MAX) ?
                        nstop_wr : num_stops_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            en_sync_reg  <= 2'h0;
            soft_rst_reg <= 1'b1;
        end else begin
            en_sync_reg  <= {en_sync_reg[0], enable_pin};
            soft_rst_reg <= ~en_sync_reg[1];
        end
    end

    // one wait cycle, then answer; the master samples while waitrequest is low
    assign accept = !avs_waitrequest && (req.read || req.write);

    always_ff @(posedge mclk) begin
        if (mrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (req.read || req.write) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= req.read ? read_next : 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (mrst) begin
            coarse_limit_high_reg <= tof_pkg::LIMIT_RESET;
            coarse_limit_low_reg  <= tof_pkg::LIMIT_RESET;
            refclk_limit_high_reg <= tof_pkg::LIMIT_RESET;
            refclk_limit_low_reg  <= tof_pkg::LIMIT_RESET;
            mode2_reg             <= 1'b0;
            num_stops_reg         <= tof_pkg::NSTOP_RESET;
            arm_tog_reg           <= 1'b0;
            clr_tog_reg           <= 1'b0;
            cfg_reg               <= '0;
        end else if (accept && req.write) begin
            unique case (req.address)
                tof_pkg::CONTROL_ADDR: begin
                    mode2_reg <= req.writedata[tof_pkg::CTRL_MODE2_BIT];
                    num_stops_reg <= nstop_next;
                    // config is frozen here and only read after the arm toggle lands
                    if (req.writedata[tof_pkg::CTRL_START_BIT] ||
                        req.writedata[tof_pkg::CTRL_CAL_BIT]) begin
                        arm_tog_reg <= ~arm_tog_reg;
                        cfg_reg     <= '{
                            mode2:        req.writedata[tof_pkg::CTRL_MODE2_BIT],
                            cal:          req.writedata[tof_pkg::CTRL_CAL_BIT],
                            num_stops:    nstop_next,
                            coarse_limit: {coarse_limit_high_reg, coarse_limit_low_reg},
                            refclk_limit: {refclk_limit_high_reg, refclk_limit_low_reg}};
                    end
                end
                tof_pkg::STATUS_ADDR: begin
                    if (req.writedata[tof_pkg::STAT_COARSE_BIT] ||
                        req.writedata[tof_pkg::STAT_REFCLK_BIT]) begin
                        clr_tog_reg <= ~clr_tog_reg;
                    end
                end
                tof_pkg::COARSE_HIGH_ADDR: coarse_limit_high_reg <= req.writedata[7:0];
                tof_pkg::COARSE_LOW_ADDR:  coarse_limit_low_reg  <= req.writedata[7:0];
                tof_pkg::REFCLK_HIGH_ADDR: refclk_limit_high_reg <= req.writedata[7:0];
                tof_pkg::REFCLK_LOW_ADDR:  refclk_limit_low_reg  <= req.writedata[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reference clock side: synchronisers and measurement engine

    tof_pkg::meas_state_type state_reg;
    logic [1:0]              rrst_sync_reg;
    logic                    rrst;
    logic [2:0]              pin_s1_reg;
    logic [2:0]              pin_s2_reg;
    logic [2:0]              pin_last_reg;
    logic [2:0]              pin_raw;
    logic [2:0]              arm_sync_reg;
    logic [2:0]              clr_sync_reg;
    logic                    start_edge;
    logic                    stop_edge;
    logic                    wrap_edge;
    logic                    arm_evt;
    logic                    clr_evt;
    logic [15:0]             coarse_cnt_reg;
    logic [15:0]             refclk_cnt_reg;
    logic [15:0]             cal_cnt_reg;
    logic [15:0]             cal_result_reg;
    logic [2:0]              idx_reg;
    logic                    coarse_overflow_flag;
    logic                    refclk_overflow_flag;
    logic                    coarse_ovf;
    logic                    refclk_ovf;
    logic [23:0]             fine_value;
    logic [23:0]             fine_time_result [0:tof_pkg::FINE_SLOTS-1];
    logic [15:0]             refclk_cycle_result [0:tof_pkg::CLK_SLOTS-1];

    assign pin_raw = {ring_wrap_pin, stop_pin, start_pin};

    always_ff @(posedge refclk) begin
        rrst_sync_reg <= {rrst_sync_reg[0], mrst};
    end
    assign rrst = rrst_sync_reg[1];

    // each pin passes two flops before any edge detector sees it
    for (genvar g = 0; g < 3; g++) begin : g_pin_sync
        always_ff @(posedge refclk) begin
            if (rrst) begin
                pin_s1_reg[g]   <= 1'b0;
                pin_s2_reg[g]   <= 1'b0;
                pin_last_reg[g] <= 1'b0;
            end else begin
                pin_s1_reg[g]   <= pin_raw[g];
                pin_s2_reg[g]   <= pin_s1_reg[g];
                pin_last_reg[g] <= pin_s2_reg[g];
            end
        end
    end

    always_ff @(posedge refclk) begin
        if (rrst) begin
            arm_sync_reg <= 3'h0;
            clr_sync_reg <= 3'h0;
        end else begin
            arm_sync_reg <= {arm_sync_reg[1:0], arm_tog_reg};
            clr_sync_reg <= {clr_sync_reg[1:0], clr_tog_reg};
        end
    end

    assign start_edge = pin_s2_reg[0] && !pin_last_reg[0];
    assign stop_edge  = pin_s2_reg[1] && !pin_last_reg[1];
    assign wrap_edge  = pin_s2_reg[2] ^ pin_last_reg[2];
    assign arm_evt    = arm_sync_reg[2] ^ arm_sync_reg[1];
    assign clr_evt    = clr_sync_reg[2] ^ clr_sync_reg[1];
    assign fine_value = {8'h00, coarse_cnt_reg} * tof_pkg::WRAP_STEPS;
    // fine result over 63 is the coarse count itself
    assign coarse_ovf = state_reg == tof_pkg::ST_RUN && coarse_cnt_reg >= cfg_reg.coarse_limit;
    assign refclk_ovf = state_reg == tof_pkg::ST_RUN && cfg_reg.mode2 &&
                        refclk_cnt_reg > cfg_reg.refclk_limit;

    always_ff @(posedge refclk) begin
        if (rrst) begin
            state_reg <= tof_pkg::ST_IDLE;
            idx_reg   <= 3'h0;
        end else if (arm_evt) begin
            state_reg <= cfg_reg.cal ? tof_pkg::ST_CAL : tof_pkg::ST_WAIT_START;
            idx_reg   <= 3'h0;
        end else begin
            unique case (state_reg)
                tof_pkg::ST_IDLE, tof_pkg::ST_DONE: ;
                tof_pkg::ST_WAIT_START: if (start_edge) state_reg <= tof_pkg::ST_RUN;
                tof_pkg::ST_RUN: begin
                    if (coarse_ovf || refclk_ovf) begin
                        state_reg <= tof_pkg::ST_DONE;
                    end else if (stop_edge) begin
                        idx_reg <= idx_reg + 3'h1;
                        if (idx_reg + 3'h1 >= cfg_reg.num_stops) begin
                            state_reg <= tof_pkg::ST_DONE;
                        end
                    end
                end
                tof_pkg::ST_CAL: if (cal_cnt_reg == tof_pkg::CAL_PERIODS) begin
                    state_reg <= tof_pkg::ST_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge refclk) begin
        if (rrst || arm_evt) begin
            coarse_cnt_reg <= 16'h0000;
        end else if ((state_reg == tof_pkg::ST_RUN || state_reg == tof_pkg::ST_CAL) &&
                     wrap_edge) begin
            coarse_cnt_reg <= coarse_cnt_reg + 16'h0001;
        end
    end

    // counting begins on the first reference edge after the start event
    always_ff @(posedge refclk) begin
        if (rrst || arm_evt) begin
            refclk_cnt_reg <= 16'h0000;
        end else if (state_reg == tof_pkg::ST_RUN && cfg_reg.mode2) begin
            refclk_cnt_reg <= refclk_cnt_reg + 16'h0001;
        end
    end

    // calibration: ring wraps across a fixed number of reference periods
    always_ff @(posedge refclk) begin
        if (rrst || arm_evt) begin
            cal_cnt_reg <= 16'h0000;
        end else if (state_reg == tof_pkg::ST_CAL) begin
            cal_cnt_reg <= cal_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge refclk) begin
        if (rrst) begin
            cal_result_reg <= 16'h0000;
        end else if (state_reg == tof_pkg::ST_CAL && cal_cnt_reg == tof_pkg::CAL_PERIODS) begin
            cal_result_reg <= coarse_cnt_reg;
        end
    end

    // a stop on the overflow cycle is dropped
    for (genvar s = 0; s < tof_pkg::FINE_SLOTS; s++) begin : g_results
        always_ff @(posedge refclk) begin
            if (rrst || arm_evt) begin
                fine_time_result[s] <= 24'h000000;
            end else if (state_reg == tof_pkg::ST_RUN && stop_edge && !coarse_ovf &&
                         !refclk_ovf && idx_reg == 3'(s)) begin
                fine_time_result[s] <= fine_value;
            end
        end
        if (s < tof_pkg::CLK_SLOTS) begin : g_clk
            always_ff @(posedge refclk) begin
                if (rrst || arm_evt) begin
                    refclk_cycle_result[s] <= 16'h0000;
                end else if (state_reg == tof_pkg::ST_RUN && cfg_reg.mode2 && stop_edge &&
                             !coarse_ovf && !refclk_ovf && idx_reg == 3'(s)) begin
                    refclk_cycle_result[s] <= refclk_cnt_reg;
                end
            end
        end
    end

    // set beats clear; flags survive the end of the run
    always_ff @(posedge refclk) begin
        if (rrst) begin
            coarse_overflow_flag <= 1'b0;
            refclk_overflow_flag <= 1'b0;
        end else begin
            if (coarse_ovf) begin
                coarse_overflow_flag <= 1'b1;
            end else if (clr_evt || arm_evt) begin
                coarse_overflow_flag <= 1'b0;
            end
            if (refclk_ovf) begin
                refclk_overflow_flag <= 1'b1;
            end else if (clr_evt || arm_evt) begin
                refclk_overflow_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // back to the system clock: status levels and readback

    always_ff @(posedge mclk) begin
        if (mrst) begin
            stat_sync1_reg <= 4'h0;
            stat_sync2_reg <= 4'h0;
        end else begin
            stat_sync1_reg <= {state_reg == tof_pkg::ST_DONE,
                               state_reg == tof_pkg::ST_WAIT_START ||
                               state_reg == tof_pkg::ST_RUN || state_reg == tof_pkg::ST_CAL,
                               refclk_overflow_flag, coarse_overflow_flag};
            stat_sync2_reg <= stat_sync1_reg;
        end
    end

    // results and the stop index are still while done is seen, so they are read as is
    always_comb begin
        read_next = 32'h00000000;
        if (req.address == tof_pkg::CONTROL_ADDR) begin
            read_next[tof_pkg::CTRL_MODE2_BIT]        = mode2_reg;
            read_next[tof_pkg::CTRL_NSTOP_LSB +: 3]  = num_stops_reg;
        end else if (req.address == tof_pkg::STATUS_ADDR) begin
            read_next[3:0] = stat_sync2_reg;
            if (stat_sync2_reg[tof_pkg::STAT_DONE_BIT]) begin
                read_next[tof_pkg::STAT_NREC_LSB +: 3] = idx_reg;
            end
        end else if (req.address == tof_pkg::COARSE_HIGH_ADDR) begin
            read_next[7:0] = coarse_limit_high_reg;
        end else if (req.address == tof_pkg::COARSE_LOW_ADDR) begin
            read_next[7:0] = coarse_limit_low_reg;
        end else if (req.address == tof_pkg::REFCLK_HIGH_ADDR) begin
            read_next[7:0] = refclk_limit_high_reg;
        end else if (req.address == tof_pkg::REFCLK_LOW_ADDR) begin
            read_next[7:0] = refclk_limit_low_reg;
        end else if (stat_sync2_reg[tof_pkg::STAT_DONE_BIT]) begin
            if (req.address == tof_pkg::CAL_RESULT_ADDR) begin
                read_next[15:0] = cal_result_reg;
            end
            for (int k = 0; k < tof_pkg::FINE_SLOTS; k++) begin
                if (req.address == tof_pkg::FINE_BASE_ADDR + 8'(k) * tof_pkg::SLOT_STRIDE) begin
                    read_next[23:0] = fine_time_result[k];
                end
            end
            for (int k = 0; k < tof_pkg::CLK_SLOTS; k++) begin
                if (req.address == tof_pkg::CLK_BASE_ADDR + 8'(k) * tof_pkg::SLOT_STRIDE) begin
                    read_next[15:0] = refclk_cycle_result[k];
                end
            end
        end
    end

    assign status_byte = {4'h0, stat_sync2_reg};

    serial_status_port u_serial (
        .mclk              (mclk),
        .rst               (mrst),
        .sclk_pin          (sclk_pin),
        .chip_select_n_pin (chip_select_n),
        .status_byte       (status_byte),
        .serial_out        (serial_out)
    );

endmodule : tof_counter_overflow

// [verif/tof_counter_overflow_assertions.sv]
// port-level checks of the counter block
module tof_counter_overflow_assertions (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        enable_pin,
    input wire logic        sclk_pin,
    input wire logic        serial_out,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic st_rd = avs_read && !avs_waitrequest && avs_address == tof_pkg::STATUS_ADDR;
    ////////////////////////////////////////
    chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest && enable_pin
        |=> !avs_waitrequest) else $error("request not answered");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    chk_reset_idle: assert property (disable iff (1'b0) rst |=> avs_waitrequest &&
        avs_readdata == 32'h00000000 && !serial_out) else $error("reset not idle");
    chk_enable_reset: assert property (!enable_pin [*5] |-> avs_waitrequest &&
        avs_readdata == 32'h00000000) else $error("enable low not reset");
    // bit moves only after a falling serial clock edge or a falling select
    chk_serial_hold: assert property (sclk_pin [*7] |-> $stable(serial_out))
        else $error("serial bit moved while clock high");
    chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'hFC
        |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
    chk_nrec_bound: assert property (st_rd |-> avs_readdata[6:4] <= tof_pkg::NSTOP_MAX)
        else $error("too many stops recorded");
    chk_flag_ends: assert property (st_rd && avs_readdata[1:0] != 2'b00 |->
        !avs_readdata[tof_pkg::STAT_BUSY_BIT]) else $error("busy after overflow");
    cover property (st_rd && avs_readdata[tof_pkg::STAT_COARSE_BIT]);
    cover property (st_rd && avs_readdata[tof_pkg::STAT_REFCLK_BIT]);
    cover property (sclk_pin [*7]);
endmodule : tof_counter_overflow_assertions

bind tof_counter_overflow tof_counter_overflow_assertions i_chk (.mclk(mclk), .rst(rst),
    .enable_pin(enable_pin), .sclk_pin(sclk_pin), .serial_out(serial_out),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// [verif/serial_host_model.sv]
// host on the serial status port: frames one byte read
module serial_host_model (
    input  wire logic mclk,
    input  wire logic serial_out,
    output logic      sclk_pin,
    output logic      chip_select_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_pin = 1'b0;
        chip_select_n = 1'b1;
    end
    task automatic read_byte(output logic [7:0] b);
        chip_select_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            repeat (8) @(posedge mclk);
            sclk_pin <= 1'b1;
            b[i] = serial_out;
            repeat (8) @(posedge mclk);
            sclk_pin <= 1'b0;
        end
        repeat (8) @(posedge mclk);
        chip_select_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask : read_byte
endmodule : serial_host_model

// [verif/tof_counter_overflow_test.sv]
// self-checking bench of the counter and overflow block
module tof_counter_overflow_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    mclk = 1'b0, refclk = 1'b0, rst = 1'b1, enable_pin = 1'b1;
    logic [2:0]              pins = 3'h0;
    tof_pkg::avalon_req_type req = '0;
    logic [31:0]             rdata, avs_readdata;
    logic [7:0]              sbyte;
    logic                    sclk_pin, chip_select_n, serial_out, avs_waitrequest;
    int                      miscompares = 0, n_tests = 0;
    ////////////////////////////////////////
    initial forever #4 mclk = ~mclk;
    initial #3 forever #24 refclk = ~refclk;
    tof_counter_overflow i_dut (.mclk(mclk), .rst(rst), .refclk(refclk), .enable_pin(enable_pin),
        .start_pin(pins[0]), .stop_pin(pins[1]), .ring_wrap_pin(pins[2]), .sclk_pin(sclk_pin),
        .chip_select_n(chip_select_n), .serial_out(serial_out), .avs_address(req.address),
        .avs_read(req.read), .avs_write(req.write), .avs_writedata(req.writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    serial_host_model i_host (.mclk(mclk), .serial_out(serial_out), .sclk_pin(sclk_pin),
        .chip_select_n(chip_select_n));
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        req <= '{read: ~wr, write: wr, address: a, writedata: d};
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        req <= '0;
        @(posedge mclk);
    endtask : bus
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // edges four reference periods apart, clear of the synchroniser
    task automatic tog(input int k, input int n);
        repeat (n) begin
            pins <= pins ^ (3'h1 << k);
            repeat (24) @(posedge mclk);
        end
    endtask : tog
    task automatic wait_idle();
        repeat (40) begin
            bus(1'b0, tof_pkg::STATUS_ADDR, 32'h00000000);
            if (rdata[tof_pkg::STAT_BUSY_BIT] === 1'b0) break;
        end
    endtask : wait_idle
    // limits go first: they are captured by the arming write
    task automatic run(input logic [31:0] lim, input logic [31:0] ctrl);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, tof_pkg::COARSE_HIGH_ADDR + 8'(4 * i), {24'h0, lim[31 - 8 * i -: 8]});
        end
        bus(1'b1, tof_pkg::CONTROL_ADDR, ctrl);
        repeat (24) @(posedge mclk);
        tog(0, 2);
    endtask : run
    task automatic test_stops();
        bus(1'b0, 8'hFC, 32'h00000000);
        check(rdata, 32'h00000000);
        run(32'hFFFFFFFF, 32'h00000011);
        tog(2, 4);
        tog(1, 2);
        tog(2, 2);
        tog(1, 2);
        wait_idle();
        check(rdata & 32'h0000007B, 32'h00000028);
        bus(1'b0, tof_pkg::FINE_BASE_ADDR + tof_pkg::SLOT_STRIDE, 32'h00000000);
        check(rdata, 32'h0000017A);
        bus(1'b0, tof_pkg::CLK_BASE_ADDR, 32'h00000000);
        check(rdata, 32'h00000000);
    endtask : test_stops
    task automatic test_coarse();
        run(32'h0003FFFF, 32'h00000011);
        tog(2, 2);
        bus(1'b0, tof_pkg::STATUS_ADDR, 32'h00000000);
        check(rdata & 32'h00000007, 32'h00000004);
        tog(2, 1);
        tog(1, 2);
        wait_idle();
        check(rdata & 32'h00000077, 32'h00000001);
        bus(1'b1, tof_pkg::STATUS_ADDR, 32'h00000001);
        repeat (40) @(posedge mclk);
        bus(1'b0, tof_pkg::STATUS_ADDR, 32'h00000000);
        check(rdata & 32'h00000003, 32'h00000000);
    endtask : test_coarse
    task automatic test_refclk();
        run(32'hFFFF0005, 32'h0000000B);
        repeat (72) @(posedge mclk);
        wait_idle();
        check(rdata & 32'h00000007, 32'h00000002);
        i_host.read_byte(sbyte);
        check({29'h0, sbyte[2:0]}, 32'h00000002);
        enable_pin <= 1'b0;
        repeat (16) @(posedge mclk);
        enable_pin <= 1'b1;
        repeat (40) @(posedge mclk);
        bus(1'b0, tof_pkg::REFCLK_LOW_ADDR, 32'h00000000);
        check(rdata, 32'h000000FF);
    endtask : test_refclk
    task automatic test_count();
        run(32'hFFFFFFFF, 32'h00000004);
        wait_idle();
        check(rdata & 32'h0000000F, 32'h00000008);
        run(32'hFFFFFFFF, 32'h0000000B);
        repeat (60) @(posedge mclk);
        tog(1, 2);
        wait_idle();
        check(rdata & 32'h0000007B, 32'h00000018);
        bus(1'b0, tof_pkg::CLK_BASE_ADDR, 32'h00000000);
        check({31'h0, rdata > 32'h0000000F && rdata < 32'h00000015}, 32'h00000001);
    endtask : test_count
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (40) @(posedge mclk); // settling wait, scaled down
        test_stops();
        test_coarse();
        test_refclk();
        test_count();
        complete_run();
    end
    initial begin
        #300000;
        miscompares++;
        complete_run();
    end
endmodule : tof_counter_overflow_test
